/* sbw_pkg.sv */
// constants shared by the standby and buffer-write command block
package sbw_pkg;
  // ==========================================================
  // command codes
  localparam logic [7:0] SBW_OP_STBY_IMM_A = 8'he0;
  localparam logic [7:0] SBW_OP_STBY_IMM_B = 8'h94;
  localparam logic [7:0] SBW_OP_BUF_WR     = 8'he8;
  localparam logic [7:0] SBW_OP_BUF_WR_DMA = 8'heb;
  localparam logic [7:0] SBW_OP_BUF_RD     = 8'he4;
  // ==========================================================
  // status field positions
  localparam int SBW_ST_BSY = 7;
  localparam int SBW_ST_RDY = 6;
  localparam int SBW_ST_DF  = 5;
  localparam int SBW_ST_DSC = 4;
  localparam int SBW_ST_DRQ = 3;
  localparam int SBW_ST_COR = 2;
  localparam int SBW_ST_IDX = 1;
  localparam int SBW_ST_ERR = 0;
  // error field positions
  localparam int SBW_ER_ABT = 2;
  // ==========================================================
  // reset values
  localparam logic [7:0] SBW_STATUS_RST = 8'h50;
  localparam logic [7:0] SBW_ERROR_RST  = 8'h00;
  // ==========================================================
  // buffer geometry: one 512-byte sector of 16-bit words
  localparam int            SBW_PTR_W     = 8;
  localparam logic [8:0]    SBW_SECT_WORDS = 9'h100;
  localparam int            SBW_BUF_DEPTH = 256;
  // ==========================================================
  // power conditions shown to the power manager
  localparam logic [1:0] SBW_PWR_ACTIVE    = 2'h0;
  localparam logic [1:0] SBW_PWR_STANDBY   = 2'h1;
  localparam logic [1:0] SBW_PWR_STANDBY_Z = 2'h2;
endpackage

/* sbw_cmd.sv */
// standby-immediate and sector buffer write/read command handler
// Behaviour
// - standby-immediate codes enter standby at once
// - standby stops spindle, interface stays alive
// - spindle already stopped: skip spin-down
// - standby commands accepted, spindle ones wait spin-up
// - standby-immediate leaves power-down timeout untouched
// - extended power enabled: enter Standby_Z instead
// - buffer write takes one PIO sector into buffer
// - data moves as 16-bit words, one per transfer
// - write and read share same 512-byte region
// - DMA buffer write stores one sector likewise
`timescale 1ns/100ps
module sbw_cmd
  import sbw_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // command register
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_code,
  input  wire logic        cmd_media,
  input  wire logic        cmd_abort,
  input  wire logic        epc_enable,
  // data register, pio and dma
  input  wire logic        pio_wr_stb,
  input  wire logic        pio_rd_stb,
  input  wire logic        dma_wr_stb,
  input  wire logic [15:0] wr_data,
  output logic      [15:0] rd_data,
  // spindle motor
  input  wire logic        spindle_at_speed,
  output logic             spindle_run,
  // results
  output logic      [7:0]  command_status_flags,
  output logic      [7:0]  command_error_flags,
  output logic             dma_request,
  output logic      [1:0]  power_state,
  output logic             ext_cmd_go,
  output logic             cmd_done
);

  // ==========================================================
  // state
  typedef enum logic [2:0] {
    SBW_IDLE, SBW_SPIN_DOWN, SBW_PIO_WR, SBW_DMA_WR, SBW_PIO_RD, SBW_SPIN_UP
  } sbw_state_type;

  sbw_state_type   state_reg;                  // command sequencer
  logic [15:0]     buf_mem [SBW_BUF_DEPTH];    // one sector of words
  logic [SBW_PTR_W-1:0] ptr_reg;               // word pointer into sector
  logic [8:0]      left_reg;                   // words still to move
  logic            at_s1_reg;                  // synchroniser stage 1
  logic            at_s2_reg;                  // synchroniser stage 2
  logic            at_s3_reg;                  // synchroniser stage 3
  logic            at_speed_reg;               // filtered spindle speed
  logic [15:0]     rd_data_reg;
  logic            spin_reg;
  logic [7:0]      status_reg;
  logic [7:0]      error_reg;
  logic            dmarq_reg;
  logic [1:0]      pwr_reg;
  logic            go_reg;
  logic            done_reg;

  // ==========================================================
  // decode
  wire is_stby   = (cmd_code == SBW_OP_STBY_IMM_A) || (cmd_code == SBW_OP_STBY_IMM_B);
  wire is_wr     = (cmd_code == SBW_OP_BUF_WR);
  wire is_wr_dma = (cmd_code == SBW_OP_BUF_WR_DMA);
  wire is_rd     = (cmd_code == SBW_OP_BUF_RD);
  wire take      = cmd_valid && (state_reg == SBW_IDLE);
  wire spun_down = !spin_reg && !at_speed_reg;
  wire need_spin = cmd_media && !at_speed_reg;
  wire last_word = (left_reg == 9'h001);
  wire wr_beat   = ((state_reg == SBW_PIO_WR) && pio_wr_stb) ||
                   ((state_reg == SBW_DMA_WR) && dma_wr_stb);
  wire rd_beat   = (state_reg == SBW_PIO_RD) && pio_rd_stb;
  // full two-bit select: a one-bit wire here would keep only the low bit and turn Standby_Z into Active
  wire [1:0] stby_code = epc_enable ? SBW_PWR_STANDBY_Z : SBW_PWR_STANDBY;

  // status words: fault and corrected always zero, busy set only in busy_status
  wire [7:0] ok_status   = (8'h01 << SBW_ST_RDY) | (8'h01 << SBW_ST_DSC);
  wire [7:0] busy_status = (8'h01 << SBW_ST_BSY);
  wire [7:0] drq_status  = (8'h01 << SBW_ST_RDY) | (8'h01 << SBW_ST_DRQ);
  wire [7:0] abt_status  = (8'h01 << SBW_ST_RDY) | (8'h01 << SBW_ST_ERR);
  wire [7:0] abt_error   = (8'h01 << SBW_ER_ABT);

  // ==========================================================
  // spindle speed input: three flops, change once 2 and 3 agree
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      at_s1_reg    <= 1'b0;
      at_s2_reg    <= 1'b0;
      at_s3_reg    <= 1'b0;
      at_speed_reg <= 1'b0;
    end else begin
      at_s1_reg <= spindle_at_speed;
      at_s2_reg <= at_s1_reg;
      at_s3_reg <= at_s2_reg;
      if (at_s2_reg == at_s3_reg) begin
        at_speed_reg <= at_s3_reg;
      end
    end
  end

  // ==========================================================
  // sector buffer array; no reset, content is data only
  always_ff @(posedge sys_clk) begin
    if (wr_beat) begin
      buf_mem[ptr_reg] <= wr_data;
    end
  end

  // ==========================================================
  // word pointer: every buffer command restarts at word zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ptr_reg  <= '0;
      left_reg <= '0;
    end else if (take && (is_wr || is_wr_dma || is_rd)) begin
      ptr_reg  <= '0;
      left_reg <= SBW_SECT_WORDS;
    end else if (wr_beat || rd_beat) begin
      ptr_reg  <= ptr_reg + 8'h01;
      left_reg <= left_reg - 9'h001;
    end
  end

  // read data: word captured on the host's read strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_data_reg <= '0;
    end else if (rd_beat) begin
      rd_data_reg <= buf_mem[ptr_reg];
    end
  end

  // ==========================================================
  // command sequencer
  // the power-down timeout lives elsewhere and is never written here
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg  <= SBW_IDLE;
      spin_reg   <= 1'b0;
      status_reg <= SBW_STATUS_RST;
      error_reg  <= SBW_ERROR_RST;
      dmarq_reg  <= 1'b0;
      pwr_reg    <= SBW_PWR_STANDBY;
      go_reg     <= 1'b0;
      done_reg   <= 1'b0;
    end else begin
      go_reg   <= 1'b0;
      done_reg <= 1'b0;
      unique case (state_reg)
        SBW_IDLE: begin
          if (take && is_stby) begin
            // no timer is consulted: enter at once
            pwr_reg   <= stby_code;
            spin_reg  <= 1'b0;
            if (spun_down) begin
              status_reg <= ok_status;
              error_reg  <= '0;
              done_reg   <= 1'b1;
            end else begin
              status_reg <= busy_status;
              state_reg  <= SBW_SPIN_DOWN;
            end
          end else if (take && is_wr) begin
            status_reg <= drq_status;
            error_reg  <= '0;
            state_reg  <= SBW_PIO_WR;
          end else if (take && is_wr_dma) begin
            status_reg <= busy_status;
            error_reg  <= '0;
            dmarq_reg  <= 1'b1;
            state_reg  <= SBW_DMA_WR;
          end else if (take && is_rd) begin
            status_reg <= drq_status;
            error_reg  <= '0;
            state_reg  <= SBW_PIO_RD;
          end else if (take && need_spin) begin
            // standby still answers; media commands wait for speed
            spin_reg   <= 1'b1;
            status_reg <= busy_status;
            state_reg  <= SBW_SPIN_UP;
          end else if (take) begin
            go_reg <= 1'b1;
          end
        end
        SBW_SPIN_DOWN: begin
          // wait for the motor to report it has left speed
          if (!at_speed_reg) begin
            status_reg <= ok_status;
            error_reg  <= '0;
            done_reg   <= 1'b1;
            state_reg  <= SBW_IDLE;
          end
        end
        SBW_SPIN_UP: begin
          if (at_speed_reg) begin
            pwr_reg    <= SBW_PWR_ACTIVE;
            status_reg <= ok_status;
            go_reg     <= 1'b1;
            state_reg  <= SBW_IDLE;
          end
        end
        SBW_PIO_WR, SBW_DMA_WR, SBW_PIO_RD: begin
          // abort wins over a final beat in the same cycle
          if (cmd_abort) begin
            status_reg <= abt_status;
            error_reg  <= abt_error;
            dmarq_reg  <= 1'b0;
            done_reg   <= 1'b1;
            state_reg  <= SBW_IDLE;
          end else if ((wr_beat || rd_beat) && last_word) begin
            status_reg <= ok_status;
            error_reg  <= '0;
            dmarq_reg  <= 1'b0;
            done_reg   <= 1'b1;
            state_reg  <= SBW_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // outputs straight from flops
  assign rd_data              = rd_data_reg;
  assign spindle_run          = spin_reg;
  assign command_status_flags = status_reg;
  assign command_error_flags  = error_reg;
  assign dma_request          = dmarq_reg;
  assign power_state          = pwr_reg;
  assign ext_cmd_go           = go_reg;
  assign cmd_done             = done_reg;

endmodule

/* sbw_chk_checker.sv */
// checker: port-level behaviour of the command block
`timescale 1ns/100ps
module sbw_chk
  import sbw_pkg::*;
(
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  // watched ports
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic       cmd_abort,
  input wire logic       epc_enable,
  input wire logic       spindle_at_speed,
  input wire logic       spindle_run,
  input wire logic [7:0] command_status_flags,
  input wire logic [7:0] command_error_flags,
  input wire logic       dma_request,
  input wire logic [1:0] power_state,
  input wire logic       cmd_done
);
  // =====================================
  // decode of accepted commands
  wire logic go = cmd_valid && !command_status_flags[SBW_ST_BSY] && !command_status_flags[SBW_ST_DRQ] && !dma_request;
  wire logic sb = go && (cmd_code == SBW_OP_STBY_IMM_A || cmd_code == SBW_OP_STBY_IMM_B);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_err_only_abt: assert property ((command_error_flags & 8'hfb) == 8'h00)
    else $error("stray error bit");
  a_done_status: assert property (cmd_done |-> (command_status_flags & 8'ha4) == 8'h00)
    else $error("done with busy, fault or corrected");
  a_stby_power: assert property (sb |=> power_state == ($past(epc_enable) ? SBW_PWR_STANDBY_Z : SBW_PWR_STANDBY))
    else $error("wrong standby power state");
  a_stby_motor: assert property (sb |=> !spindle_run)
    else $error("spindle left running");
  a_stby_skip: assert property (sb && !spindle_run && !spindle_at_speed && !$past(spindle_at_speed, 4)
    |=> cmd_done && command_status_flags == 8'h50)
    else $error("spin-down not skipped");
  a_stby_spin: assert property (sb && spindle_at_speed && $past(spindle_at_speed, 4) |=> command_status_flags == 8'h80)
    else $error("no busy while spinning down");
  a_wr_pio: assert property (go && cmd_code == SBW_OP_BUF_WR |=> command_status_flags == 8'h48)
    else $error("pio write not requesting data");
  a_wr_dma: assert property (go && cmd_code == SBW_OP_BUF_WR_DMA |=> dma_request && command_status_flags == 8'h80)
    else $error("dma write not requesting");
  a_abort_dma: assert property (dma_request && cmd_abort |=> command_status_flags == 8'h41 && command_error_flags == 8'h04)
    else $error("abort not reported");
  a_done_pulse: assert property (cmd_done |=> !cmd_done)
    else $error("done longer than a cycle");
endmodule
bind sbw_cmd sbw_chk u_chk (.sys_clk, .rst, .cmd_valid, .cmd_code, .cmd_abort, .epc_enable, .spindle_at_speed,
  .spindle_run, .command_status_flags, .command_error_flags, .dma_request, .power_state, .cmd_done);

/* sbw_motor_model.sv */
// spindle motor stand-in: speed flag follows the drive after a spin time
`timescale 1ns/100ps
module sbw_motor_model #(parameter int SPIN = 12) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // motor drive and speed sense
  input wire logic spindle_run,
  output logic     spindle_at_speed
);
  logic [7:0] cnt_reg; // cycles spent changing speed
  // slow both ways, so the block must really wait for the sense line
  always_ff @(posedge sys_clk) begin
    if (rst || spindle_run == spindle_at_speed) begin
      cnt_reg <= 8'h00;
      if (rst) spindle_at_speed <= 1'b0;
    end else if (cnt_reg == SPIN[7:0]) begin
      spindle_at_speed <= spindle_run;
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule

/* tb_top.sv */
// testbench: standby, buffer write and read-back sequences
`timescale 1ns/100ps
module tb_top;
  import sbw_pkg::*;
  logic sys_clk = 0, rst = 1, cmd_valid = 0, cmd_media = 0, cmd_abort = 0, epc_enable = 0;
  logic pio_wr_stb = 0, pio_rd_stb = 0, dma_wr_stb = 0, spindle_at_speed, spindle_run;
  logic [7:0] cmd_code = 8'h00, command_status_flags, command_error_flags;
  logic [15:0] wr_data = 16'h0000, rd_data;
  logic dma_request, ext_cmd_go, cmd_done;
  logic [1:0] power_state;
  int failures = 0, num_checks = 0;
  sbw_cmd DUT (.sys_clk, .rst, .cmd_valid, .cmd_code, .cmd_media, .cmd_abort, .epc_enable, .pio_wr_stb, .pio_rd_stb,
    .dma_wr_stb, .wr_data, .rd_data, .spindle_at_speed, .spindle_run, .command_status_flags, .command_error_flags,
    .dma_request, .power_state, .ext_cmd_go, .cmd_done);
  sbw_motor_model u_motor (.sys_clk, .rst, .spindle_run, .spindle_at_speed);
  initial forever #10 sys_clk = ~sys_clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one command pulse; returns just after its sampling edge
  task automatic issue(input logic [7:0] c, input logic m);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_media <= m;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    #1;
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (cmd_done !== 1'b1 && ext_cmd_go !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n >= 3000) failures++;
  endtask
  // n words, one per strobe, word i carries its index
  task automatic fill(input logic dma, input logic [7:0] seed, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      pio_wr_stb <= !dma;
      dma_wr_stb <= dma;
      wr_data <= {seed ^ 8'(i), 8'(i)};
    end
    @(posedge sys_clk);
    pio_wr_stb <= 1'b0;
    dma_wr_stb <= 1'b0;
    #1;
  endtask
  task automatic drain(input logic [7:0] seed);
    issue(SBW_OP_BUF_RD, 1'b0);
    for (int i = 0; i < 256; i++) begin
      @(posedge sys_clk);
      pio_rd_stb <= 1'b1;
      @(posedge sys_clk);
      pio_rd_stb <= 1'b0;
      #1;
      chk(rd_data, {seed ^ 8'(i), 8'(i)});
    end
    wait_done();
  endtask
  // =====================================
  // main sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    // spindle stopped: both codes, plain and extended power
    for (int k = 0; k < 2; k++) begin
      epc_enable <= k[0];
      issue(k ? SBW_OP_STBY_IMM_B : SBW_OP_STBY_IMM_A, 1'b0);
      chk(cmd_done, 1'b1);
      chk(power_state, k ? SBW_PWR_STANDBY_Z : SBW_PWR_STANDBY);
      chk(command_status_flags, SBW_STATUS_RST);
    end
    epc_enable <= 1'b0;
    // spindle command in standby waits for spin-up
    issue(8'h20, 1'b1);
    chk(spindle_run, 1'b1);
    chk(command_status_flags, 8'h80);
    wait_done();
    chk(ext_cmd_go, 1'b1);
    chk(power_state, SBW_PWR_ACTIVE);
    // standby while spinning
    issue(SBW_OP_STBY_IMM_A, 1'b0);
    chk(command_status_flags, 8'h80);
    chk(spindle_run, 1'b0);
    wait_done();
    chk(command_status_flags, 8'h50);
    // spindle-free command in standby is forwarded at once
    issue(8'h20, 1'b0);
    chk(ext_cmd_go, 1'b1);
    chk(spindle_run, 1'b0);
    // pio sector, then dma sector, each read back
    issue(SBW_OP_BUF_WR, 1'b0);
    chk(command_status_flags, 8'h48);
    fill(1'b0, 8'h3c, 256);
    wait_done();
    chk(command_status_flags, 8'h50);
    chk(command_error_flags, 8'h00);
    drain(8'h3c);
    issue(SBW_OP_BUF_WR_DMA, 1'b0);
    chk(dma_request, 1'b1);
    fill(1'b1, 8'hc3, 256);
    wait_done();
    chk(dma_request, 1'b0);
    drain(8'hc3);
    // abort in mid-sector
    issue(SBW_OP_BUF_WR_DMA, 1'b0);
    fill(1'b1, 8'h55, 9);
    @(posedge sys_clk);
    cmd_abort <= 1'b1;
    @(posedge sys_clk);
    cmd_abort <= 1'b0;
    #1;
    chk(command_status_flags, 8'h41);
    chk(command_error_flags, 8'h04);
    test_done();
  end
  // hang guard, well beyond the expected run
  initial begin
    repeat (6000) @(posedge sys_clk);
    failures++;
    test_done();
  end
endmodule
